// ### verilog/staged_config_defs.svh
// Constants for the staged configuration completer
`ifndef STAGED_CONFIG_DEFS_SVH
`define STAGED_CONFIG_DEFS_SVH

`define CRIT_W 8
`define CRIT_IDLE 8'h00
`define RDY_MIN_CYC 4'h2
`define RDY_MAX_CYC 4'hc
`define BITSTREAM_BAR 3'h0
`define BAR0_APERTURE_LOG2 5'h1b
`define FMT_DATA_BIT 30
`define FMT_4DW_BIT 29
`define FMT_HI 31
`define FMT_LO 29
`define TYPE_HI 28
`define TYPE_LO 24
`define TC_HI 22
`define TC_LO 20
`define REQID_HI 31
`define REQID_LO 16
`define TAG_HI 15
`define TAG_LO 8
`define LOADDR_HI 6
`define LOADDR_LO 0
`define TYPE_MEM 5'h00
`define FMT_CPLD 3'h2
`define TYPE_CPL 5'h0a
`define CPL_STATUS_OK 3'h0
`define CPL_BYTES 12'h004
`define CPL_LEN 10'h001
`define CPL_LAST 2'h3
`define HDR_LAST_3DW 2'h2
`define HDR_LAST_4DW 2'h3
`define HDR_REQ_WORD 2'h1

`endif

// ### verilog/staged_config_pkg.sv
// Types for the staged configuration completer
package staged_config_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR  = 5'b00010,
        ST_DATA = 5'b00100,
        ST_DROP = 5'b01000,
        ST_CPL  = 5'b10000
    } rx_state_t;

    typedef enum logic [1:0] {
        KIND_READ  = 2'b01,
        KIND_WRITE = 2'b10
    } req_kind_t;

endpackage : staged_config_pkg

// ### verilog/critical_input_gate.sv
// Holds critical core inputs at idle levels until stage two is ready
`timescale 1ns/1ps
`include "staged_config_defs.svh"

module critical_input_gate (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_app_rdy,
    input wire logic [`CRIT_W-1:0] i_user_crit,
    output logic [`CRIT_W-1:0] o_core_crit
);
    localparam logic [`CRIT_W-1:0] IDLE_LEVELS = `CRIT_IDLE;

    genvar b;
    generate
        for (b = 0; b < `CRIT_W; b++) begin : g_bit
            always_ff @(posedge i_mclk) begin
                if (i_reset) begin
                    o_core_crit[b] <= IDLE_LEVELS[b];
                end else if (i_app_rdy) begin
                    o_core_crit[b] <= i_user_crit[b]; // [RL3]
                end else begin
                    o_core_crit[b] <= IDLE_LEVELS[b]; // [RL1] [RL2]
                end
            end
        end
    endgenerate

    chk_gate_idle: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL2]
        !i_app_rdy |=> o_core_crit == IDLE_LEVELS)
        else $error("Critical inputs not held idle before ready");

    chk_gate_pass: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL3]
        i_app_rdy |=> o_core_crit == $past(i_user_crit))
        else $error("Critical inputs not passed after ready");

endmodule : critical_input_gate

// ### verilog/staged_config_completer.sv
// First-stage completer: drains requests, loads bitstream, hands off to user
`timescale 1ns/1ps
`include "staged_config_defs.svh"

// What this block does
// RL1 - Critical core inputs pass through a gate disabled during stage two loading.
// RL2 - While loading, gated inputs are forced to their deasserted idle levels.
// RL3 - Once ready asserts, gated inputs follow the user-side sources.
// RL4 - Unhandled received requests are drained so configuration traffic never locks up.
// RL5 - Completer logic is active only when the staged mode parameter is set; otherwise it stays built but idle.
// RL6 - Host sends single-word reads; each gets a completion with zero data.
// RL7 - Vendor messages are taken from the receive stream and discarded.
// RL8 - Memory writes hitting BAR0 carry second-stage bitstream data.
// RL9 - Accepted bitstream write payload goes to the configuration access port.
// RL10 - After ready asserts the completer goes inactive and handles nothing.
// RL11 - BAR0 aperture is a 128 megabyte memory window.
// RL12 - Host delivers the bitstream as 32-bit aligned memory writes.
// RL13 - Ready asserts 2 to 12 cycles after stage two, between packets unless forced at the 12-cycle bound.
// RL14 - End of startup marks stage two loaded and triggers the ready handoff.
// RL15 - User logic leaves configuration and startup ports alone until ready.
// RL16 - Completions copy requester id, tag, traffic class; status successful.
module staged_config_completer
    import staged_config_pkg::*;
#(
    parameter bit STAGED_MODE = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_end_of_startup,
    input wire logic [15:0] i_completer_id,
    input wire logic [31:0] i_rx_data,
    input wire logic i_rx_valid,
    input wire logic i_rx_sop,
    input wire logic i_rx_eop,
    input wire logic [2:0] i_rx_bar_id,
    output logic o_rx_ready,
    output logic [31:0] o_tx_data,
    output logic o_tx_valid,
    output logic o_tx_sop,
    output logic o_tx_eop,
    input wire logic i_tx_ready,
    output logic [31:0] o_icap_data,
    output logic o_icap_valid,
    input wire logic [`CRIT_W-1:0] i_user_crit,
    output logic [`CRIT_W-1:0] o_core_crit,
    output logic [4:0] o_bar0_aperture_log2,
    output logic o_user_app_rdy
);
    logic eos_s1;
    logic eos_s2;
    logic eos_s3;
    logic eos_stable;
    logic [3:0] rdy_cnt;
    logic next_rdy;
    logic active;
    rx_state_t state;
    rx_state_t next_state;
    req_kind_t kind;
    logic [1:0] hdr_idx;
    logic [1:0] hdr_last;
    logic bar_ok;
    logic [15:0] req_id;
    logic [7:0] req_tag;
    logic [2:0] req_tc;
    logic [6:0] low_addr;
    logic [1:0] cpl_idx;
    logic rx_fire;
    logic tx_fire;

    // End-of-startup crosses in through three flops
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            eos_s1 <= 1'b0;
            eos_s2 <= 1'b0;
            eos_s3 <= 1'b0;
        end else begin
            eos_s1 <= i_end_of_startup;
            eos_s2 <= eos_s1;
            eos_s3 <= eos_s2;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            eos_stable <= 1'b0;
        end else if (eos_s2 == eos_s3) begin
            eos_stable <= eos_s3 | eos_stable; // [RL14]
        end
    end

    // Handoff waits for an idle receive path, forced at the upper bound
    always_comb begin
        next_rdy = o_user_app_rdy;
        if (eos_stable) begin
            if ((rdy_cnt >= `RDY_MIN_CYC - 4'h1 && state == ST_IDLE && !i_rx_valid)
                || rdy_cnt == `RDY_MAX_CYC - 4'h1) begin
                next_rdy = 1'b1; // [RL13] [RL14]
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdy_cnt <= 4'h0;
            o_user_app_rdy <= 1'b0;
        end else begin
            if (eos_stable && rdy_cnt != `RDY_MAX_CYC) begin
                rdy_cnt <= rdy_cnt + 4'h1;
            end
            o_user_app_rdy <= next_rdy;
        end
    end

    assign active = STAGED_MODE && !o_user_app_rdy; // [RL5] [RL10]
    assign rx_fire = i_rx_valid && o_rx_ready;
    assign tx_fire = o_tx_valid && i_tx_ready;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_bar0_aperture_log2 <= 5'h0;
        end else begin
            o_bar0_aperture_log2 <= `BAR0_APERTURE_LOG2; // [RL11]
        end
    end

    critical_input_gate u_gate (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_app_rdy(o_user_app_rdy), // [RL1]
        .i_user_crit(i_user_crit),
        .o_core_crit(o_core_crit)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (rx_fire && i_rx_sop) begin
                    if (i_rx_data[`TYPE_HI:`TYPE_LO] == `TYPE_MEM) begin
                        next_state = ST_HDR;
                    end else if (!i_rx_eop) begin
                        next_state = ST_DROP; // [RL4] [RL7]
                    end
                end
            end
            ST_HDR: begin
                if (rx_fire && hdr_idx == hdr_last) begin
                    if (kind == KIND_READ) begin
                        next_state = ST_CPL; // [RL6]
                    end else if (i_rx_eop) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_DATA;
                    end
                end
            end
            ST_DATA, ST_DROP: begin
                if (rx_fire && i_rx_eop) begin
                    next_state = ST_IDLE;
                end
            end
            ST_CPL: begin
                if (tx_fire && cpl_idx == `CPL_LAST) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
        if (!active) begin
            next_state = ST_IDLE; // [RL10]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state <= ST_IDLE;
            o_rx_ready <= 1'b0;
        end else begin
            state <= next_state;
            o_rx_ready <= active && next_state != ST_CPL; // [RL4] [RL10]
        end
    end

    // Header capture
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            kind <= KIND_READ;
            hdr_idx <= 2'h0;
            hdr_last <= `HDR_LAST_3DW;
            bar_ok <= 1'b0;
            req_id <= 16'h0;
            req_tag <= 8'h0;
            req_tc <= 3'h0;
            low_addr <= 7'h0;
        end else if (rx_fire) begin
            if (state == ST_IDLE && i_rx_sop) begin
                kind <= i_rx_data[`FMT_DATA_BIT] ? KIND_WRITE : KIND_READ;
                hdr_last <= i_rx_data[`FMT_4DW_BIT] ? `HDR_LAST_4DW : `HDR_LAST_3DW;
                req_tc <= i_rx_data[`TC_HI:`TC_LO]; // [RL16]
                bar_ok <= i_rx_bar_id == `BITSTREAM_BAR; // [RL8]
                hdr_idx <= `HDR_REQ_WORD;
            end else if (state == ST_HDR) begin
                hdr_idx <= hdr_idx + 2'h1;
                if (hdr_idx == `HDR_REQ_WORD) begin
                    req_id <= i_rx_data[`REQID_HI:`REQID_LO]; // [RL16]
                    req_tag <= i_rx_data[`TAG_HI:`TAG_LO];
                end
                if (hdr_idx == hdr_last) begin
                    low_addr <= i_rx_data[`LOADDR_HI:`LOADDR_LO];
                end
            end
        end
    end

    // Bitstream words to the configuration access port
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_icap_data <= 32'h0;
            o_icap_valid <= 1'b0;
        end else begin
            o_icap_valid <= rx_fire && state == ST_DATA && bar_ok && active; // [RL8] [RL9]
            if (rx_fire && state == ST_DATA) begin
                o_icap_data <= i_rx_data; // [RL9]
            end
        end
    end

    // Zero-data completion, four words
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_tx_data <= 32'h0;
            o_tx_valid <= 1'b0;
            o_tx_sop <= 1'b0;
            o_tx_eop <= 1'b0;
            cpl_idx <= 2'h0;
        end else if (!active) begin
            o_tx_valid <= 1'b0; // [RL10]
            o_tx_sop <= 1'b0;
            o_tx_eop <= 1'b0;
        end else if (state != ST_CPL && next_state == ST_CPL) begin
            o_tx_valid <= 1'b1;
            o_tx_sop <= 1'b1;
            o_tx_eop <= 1'b0;
            cpl_idx <= 2'h0;
            o_tx_data <= {`FMT_CPLD, `TYPE_CPL, 1'b0, req_tc, 10'h0, `CPL_LEN}; // [RL16]
        end else if (tx_fire) begin
            cpl_idx <= cpl_idx + 2'h1;
            o_tx_sop <= 1'b0;
            unique case (cpl_idx)
                2'h0: o_tx_data <= {i_completer_id, `CPL_STATUS_OK, 1'b0, `CPL_BYTES}; // [RL16]
                2'h1: o_tx_data <= {req_id, req_tag, 1'b0, low_addr}; // [RL16]
                2'h2: o_tx_data <= 32'h0; // [RL6]
                2'h3: o_tx_data <= 32'h0;
            endcase
            o_tx_eop <= cpl_idx == `CPL_LAST - 2'h1;
            o_tx_valid <= cpl_idx != `CPL_LAST;
        end
    end

    sequence s_eos_rise;
        $rose(eos_stable);
    endsequence

    sequence s_rdy_wait;
        !o_user_app_rdy ##1 !o_user_app_rdy ##[1:11] o_user_app_rdy;
    endsequence

    chk_rdy_window: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL13]
        s_eos_rise |-> s_rdy_wait)
        else $error("Ready outside two to twelve cycles");

    chk_rdy_sticky: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL14]
        o_user_app_rdy |=> o_user_app_rdy && eos_stable)
        else $error("Ready dropped or rose without startup end");

    chk_cpl_zero: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL6]
        o_tx_valid && cpl_idx == `CPL_LAST |-> o_tx_data == 32'h0 && o_tx_eop)
        else $error("Completion payload not zero");

    chk_cpl_ids: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL16]
        o_tx_valid && cpl_idx == 2'h2 |-> o_tx_data[31:16] == req_id && o_tx_data[15:8] == req_tag)
        else $error("Completion ids not copied");

    chk_icap_fwd: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL9]
        rx_fire && state == ST_DATA && bar_ok && active |=> o_icap_valid && o_icap_data == $past(i_rx_data))
        else $error("Bitstream word not forwarded");

    chk_bar_filter: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL8]
        rx_fire && state == ST_DATA && !bar_ok |=> !o_icap_valid)
        else $error("Non-BAR0 write reached config port");

    chk_drain: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL7]
        state == ST_DROP && active |-> o_rx_ready)
        else $error("Drained packet stalled");

    chk_inactive: assert property (@(posedge i_mclk) disable iff (i_reset) // [RL10]
        o_user_app_rdy ##1 o_user_app_rdy |-> !o_rx_ready && !o_icap_valid && !o_tx_valid)
        else $error("Completer active after handoff");

endmodule : staged_config_completer

// ### test/pcie_host_model.sv
// Host model: issues request packets and sinks completions
`timescale 1ns/1ps
module pcie_host_model (
    input wire logic i_mclk,
    input wire logic i_slow,
    input wire logic i_rx_ready,
    output logic [31:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_rx_sop,
    output logic o_rx_eop,
    output logic [2:0] o_rx_bar_id,
    input wire logic [31:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready
);
    logic [31:0] got[$];
    initial begin
        o_rx_data = 32'h0;
        o_rx_valid = 1'b0;
        o_rx_sop = 1'b0;
        o_rx_eop = 1'b0;
        o_rx_bar_id = 3'h0;
        o_tx_ready = 1'b1;
    end
    always @(negedge i_mclk) begin
        o_tx_ready <= i_slow ? 1'($urandom) : 1'b1;
    end
    always @(posedge i_mclk) begin
        if (i_tx_valid && o_tx_ready) begin
            got.push_back(i_tx_data);
        end
    end
    // Whole aligned 32-bit words, one per beat
    task automatic send(input logic [31:0] w[$], input logic [2:0] bar);
        for (int i = 0; i < w.size(); i++) begin
            @(negedge i_mclk);
            o_rx_valid = 1'b1;
            o_rx_data = w[i];
            o_rx_sop = (i == 0);
            o_rx_eop = (i == w.size() - 1);
            o_rx_bar_id = bar;
            while (!i_rx_ready) @(negedge i_mclk);
            @(posedge i_mclk);
        end
        @(negedge i_mclk);
        o_rx_valid = 1'b0;
        o_rx_sop = 1'b0;
        o_rx_eop = 1'b0;
        o_rx_data = ~o_rx_data;
    endtask : send
endmodule : pcie_host_model

// ### test/tb_staged_config_completer.sv
// Self-checking bench for the staged configuration completer
`timescale 1ns/1ps
`include "staged_config_defs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_staged_config_completer;
    logic i_mclk, i_reset, end_of_startup, slow, rx_valid, rx_sop, rx_eop, rx_ready, tx_valid, tx_sop, tx_eop, tx_ready;
    logic icap_valid, app_rdy;
    logic [15:0] cid;
    logic [7:0] ucrit, core_crit;
    logic [31:0] rx_data, tx_data, icap_data, exp_icap[$], exp_cpl[$], icap_got[$], pkt[$];
    logic [2:0] bar_id;
    logic [4:0] aperture;
    int fail_count = 0;
    int tests_run = 0;
    int n;
    int tx_beat = 0;
    logic off_rx_ready, off_icap_valid;
    staged_config_completer DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_end_of_startup(end_of_startup),
        .i_completer_id(cid), .i_rx_data(rx_data), .i_rx_valid(rx_valid), .i_rx_sop(rx_sop),
        .i_rx_eop(rx_eop), .i_rx_bar_id(bar_id), .o_rx_ready(rx_ready), .o_tx_data(tx_data),
        .o_tx_valid(tx_valid), .o_tx_sop(tx_sop), .o_tx_eop(tx_eop), .i_tx_ready(tx_ready),
        .o_icap_data(icap_data), .o_icap_valid(icap_valid), .i_user_crit(ucrit),
        .o_core_crit(core_crit), .o_bar0_aperture_log2(aperture), .o_user_app_rdy(app_rdy));
    pcie_host_model host (.i_mclk(i_mclk), .i_slow(slow), .i_rx_ready(rx_ready), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .o_rx_sop(rx_sop), .o_rx_eop(rx_eop), .o_rx_bar_id(bar_id),
        .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));
    // Trimmed build without staged mode: must never take or forward anything
    staged_config_completer #(.STAGED_MODE(1'b0)) dut_trim (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_end_of_startup(end_of_startup), .i_completer_id(cid), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
        .i_rx_sop(rx_sop), .i_rx_eop(rx_eop), .i_rx_bar_id(bar_id), .o_rx_ready(off_rx_ready),
        .o_tx_data(), .o_tx_valid(), .o_tx_sop(), .o_tx_eop(), .i_tx_ready(tx_ready),
        .o_icap_data(), .o_icap_valid(off_icap_valid), .i_user_crit(ucrit), .o_core_crit(),
        .o_bar0_aperture_log2(), .o_user_app_rdy());
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (icap_valid) begin
            icap_got.push_back(icap_data);
        end
    end
    // Completion framing and trimmed-build silence
    always @(posedge i_mclk) begin
        if (tx_valid && tx_ready) begin
            `CHK("tx_sop", tx_beat == 0, tx_sop)
            `CHK("tx_eop", tx_beat == 3, tx_eop)
            tx_beat = (tx_beat + 1) % 4;
        end
        if (rx_valid) begin
            `CHK("trim_rx_ready", 1'b0, off_rx_ready)
            `CHK("trim_icap_valid", 1'b0, off_icap_valid)
        end
    end
    task automatic summarize();
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk_q(input string nm, input logic [31:0] e[$], input logic [31:0] g[$]);
        `CHK({nm, "_count"}, e.size(), g.size())
        for (int i = 0; i < e.size() && i < g.size(); i++) begin
            `CHK(nm, e[i], g[i])
        end
    endtask : chk_q
    task automatic rd(input logic [2:0] tc, input logic [15:0] rid, input logic [7:0] tag, input logic [31:0] a);
        pkt = '{{3'b000, 5'h00, 1'b0, tc, 10'h0, 10'h001}, {rid, tag, 8'h0f}, {a[31:2], 2'b00}};
        host.send(pkt, 3'h0);
        exp_cpl.push_back({`FMT_CPLD, `TYPE_CPL, 1'b0, tc, 10'h0, `CPL_LEN});
        exp_cpl.push_back({cid, `CPL_STATUS_OK, 1'b0, `CPL_BYTES});
        exp_cpl.push_back({rid, tag, 1'b0, a[6:2], 2'b00});
        exp_cpl.push_back(32'h0);
    endtask : rd
    task automatic wr(input bit four, input logic [2:0] bar, input int len);
        logic [31:0] d;
        pkt = {};
        pkt.push_back({four ? 3'b011 : 3'b010, 5'h00, 1'b0, 3'h0, 10'h0, 10'(len)});
        pkt.push_back(32'h0000_00ff);
        if (four) pkt.push_back(32'h0);
        pkt.push_back($urandom & 32'h07ff_fffc);
        for (int i = 0; i < len; i++) begin
            d = $urandom;
            pkt.push_back(d);
            if (bar == 3'h0) exp_icap.push_back(d);
        end
        host.send(pkt, bar);
    endtask : wr
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        summarize();
    end
    initial begin
        void'($urandom(32'h479e8914));
        i_reset = 1'b1;
        end_of_startup = 1'b0;
        slow = 1'b0;
        cid = 16'($urandom);
        ucrit = 8'($urandom);
        repeat (4) @(negedge i_mclk);
        `CHK("rst_rdy", 1'b0, app_rdy)
        `CHK("rst_aperture", 5'h00, aperture)
        i_reset = 1'b0;
        @(negedge i_mclk);
        `CHK("aperture", `BAR0_APERTURE_LOG2, aperture)
        `CHK("crit_gated", `CRIT_IDLE, core_crit)
        wr(1'b0, 3'h0, 5);
        wr(1'b1, 3'h0, 1);
        wr(1'b0, 3'h2, 3);
        repeat (3) @(negedge i_mclk);
        chk_q("icap", exp_icap, icap_got);
        exp_icap = {};
        icap_got = {};
        for (int k = 0; k < 2; k++) begin
            pkt = '{k ? 32'h7400_0001 : 32'h3400_0000, 32'h0000_007f, 32'h0, 32'h0};
            if (k) pkt.push_back($urandom);
            host.send(pkt, 3'h0);
        end
        rd(3'($urandom), 16'($urandom), 8'($urandom), $urandom);
        slow = 1'b1;
        rd(3'($urandom), 16'($urandom), 8'($urandom), $urandom);
        rd(3'h7, 16'hffff, 8'hff, 32'h0000_007c);
        for (int k = 0; k < 200 && host.got.size() < exp_cpl.size(); k++) @(negedge i_mclk);
        slow = 1'b0;
        chk_q("cpl", exp_cpl, host.got);
        chk_q("icap_msg", exp_icap, icap_got);
        ucrit = 8'($urandom) | 8'h01;
        @(negedge i_mclk);
        `CHK("crit_loading", `CRIT_IDLE, core_crit)
        end_of_startup = 1'b1;
        n = 0;
        while (app_rdy !== 1'b1 && n < 30) begin
            @(negedge i_mclk);
            n++;
        end
        `CHK("rdy_window", 1'b1, n >= `RDY_MIN_CYC + 4 && n <= `RDY_MAX_CYC + 4)
        // User side drives a new value on its ports once ready has asserted
        ucrit = 8'($urandom);
        @(negedge i_mclk);
        `CHK("crit_user", ucrit, core_crit)
        repeat (8) begin
            @(negedge i_mclk);
            `CHK("rx_ready_off", 1'b0, rx_ready)
            `CHK("tx_valid_off", 1'b0, tx_valid)
            `CHK("icap_valid_off", 1'b0, icap_valid)
        end
        summarize();
    end
endmodule : tb_staged_config_completer
